/* design/scc_pkg.sv */
// shared constants and types for the serial bus configuration block
package scc_pkg;

	// configuration register field positions
	localparam int BIT_IFACE_ON    = 7;
	localparam int BIT_INHIBIT     = 6;
	localparam int BIT_ACTIVE      = 5;
	localparam int BIT_HOLD_EXT    = 4;
	localparam int BIT_TOE         = 3;
	localparam int BIT_FTE         = 2;
	localparam int BIT_SRC_HI      = 1;
	localparam int BIT_SRC_LO      = 0;

	// register layout, msb first
	typedef struct packed {
		logic       iface_on;
		logic       slave_inhibit;
		logic       transfer_active;
		logic       hold_extension;
		logic       clock_low_timeout_en;
		logic       free_timeout_en;
		logic [1:0] bit_rate_source_sel;
	} scc_cfg_t;

	localparam scc_cfg_t CFG_RESET = 8'h00;

	// overflow source codes
	typedef enum logic [1:0] {
		SRC_TIMER0    = 2'h0,
		SRC_TIMER1    = 2'h1,
		SRC_TIMER2_HI = 2'h2,
		SRC_TIMER2_LO = 2'h3
	} scc_src_t;

	localparam int NUM_SOURCES = 4;

	// free bus detection: more than this many source periods with both lines high
	localparam logic [3:0] FREE_PERIODS = 4'ha;

	// master clock phases in overflow periods; high is typically twice low
	localparam logic [1:0] LOW_OVF  = 2'h1;
	localparam logic [1:0] HIGH_OVF = 2'h2;

	// data line setup and hold minimums in system clocks
	localparam logic [3:0] SETUP_NORM = 4'h1;
	localparam logic [3:0] SETUP_EXT  = 4'hb;
	localparam logic [3:0] HOLD_NORM  = 4'h3;
	localparam logic [3:0] HOLD_EXT   = 4'hc;

endpackage : scc_pkg

/* design/scc_sync.sv */
// two flip-flop synchroniser for a group of levels
`timescale 1ns/10ps
module scc_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset of the receiving domain
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	// levels in and out
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] meta;

	// the first stage feeds only the second
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			meta <= '0;
			q_o  <= '0;
		end
		else
		begin
			meta <= d_i;
			q_o  <= meta;
		end
	end

endmodule : scc_sync

/* design/scc_config_control.sv */
// configuration, busy tracking, timeouts and clock source for the serial bus
`timescale 1ns/10ps
module scc_config_control
	import scc_pkg::*;
(
	// system clock and reset
	input  wire logic                            sys_clk_i,
	input  wire logic                            reset_i,
	// link clock sampling the bus pins
	input  wire logic                            link_clk_i,
	// configuration register port
	input  wire logic                            cfg_wr_i,
	input  wire scc_pkg::scc_cfg_t               cfg_wdata_i,
	output scc_pkg::scc_cfg_t                    cfg_rdata_o,
	// bus pins
	input  wire logic                            scl_pin_i,
	input  wire logic                            sda_pin_i,
	output logic                                 scl_o,
	output logic                                 scl_oe_o,
	// timer overflow pulses and timeout timer control
	input  wire logic [scc_pkg::NUM_SOURCES-1:0] ovf_i,
	input  wire logic                            split_mode_i,
	output logic                                 reload_hi_o,
	output logic                                 reload_lo_o,
	// engine side
	input  wire logic                            master_active_i,
	input  wire logic                            master_clk_req_i,
	input  wire logic                            master_event_i,
	input  wire logic                            slave_event_i,
	output logic                                 irq_event_o,
	output logic                                 slave_ack_allow_o,
	output logic                                 iface_on_o,
	output logic [3:0]                           setup_cycles_o,
	output logic [3:0]                           hold_cycles_o
);

	typedef enum logic [1:0] {
		M_IDLE,
		M_LOW,
		M_HIGH
	} scc_mst_t;

	// link domain
	logic [1:0] pin_meta;
	logic [1:0] pin_s;
	logic [1:0] pin_prev;
	logic       start_tgl;
	logic       stop_tgl;
	wire        link_scl      = pin_s[0];
	wire        link_sda      = pin_s[1];
	wire        link_start    = link_scl && pin_prev[0] && pin_prev[1] && !link_sda;
	wire        link_stop     = link_scl && pin_prev[0] && !pin_prev[1] && link_sda;

	// sys domain
	scc_cfg_t   cfg;
	logic       busy;
	logic       inh_eff;
	logic [3:0] xq;
	logic [1:0] tgl_prev;
	logic [3:0] free_cnt;
	logic       bus_free;
	logic [1:0] phase_cnt;
	scc_mst_t   mst;
	scc_mst_t   next_mst;
	logic [1:0] next_phase_cnt;
	logic       next_busy;
	logic       next_inh_eff;
	logic [3:0] next_free_cnt;

	// level and toggle crossings into the system clock
	scc_sync #(
		.WIDTH (4)
	) u_sync (
		.clk_i   (sys_clk_i),
		.reset_i (reset_i),
		.d_i     ({link_sda, link_scl, stop_tgl, start_tgl}),
		.q_o     (xq)
	);

	wire        scl_s        = xq[2];
	wire        sda_s        = xq[3];
	wire        start_evt    = cfg.iface_on && (xq[0] ^ tgl_prev[0]);
	wire        stop_evt     = cfg.iface_on && (xq[1] ^ tgl_prev[1]);
	wire        lines_high   = scl_s && sda_s;
	// timers may be shared, so the pulse is only consumed when actually needed
	wire        ovf_used     = cfg.iface_on && (master_active_i || cfg.free_timeout_en);
	wire        src_ovf      = ovf_i[cfg.bit_rate_source_sel];
	wire        sel_ovf      = ovf_used && src_ovf;
	wire        free_armed   = cfg.iface_on && cfg.free_timeout_en && lines_high;
	wire        free_hit     = free_armed && sel_ovf && (free_cnt == FREE_PERIODS);
	wire        hold_reload  = cfg.iface_on && cfg.clock_low_timeout_en && scl_s;
	wire        slave_irq    = slave_event_i && !inh_eff;
	wire        next_irq     = cfg.iface_on && (master_event_i || slave_irq);
	wire        wr_inhibit   = cfg_wdata_i.slave_inhibit;
	scc_cfg_t   live_cfg;

	// link domain pin sampling; start and stop become toggles for the crossing
	always_ff @(posedge link_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			pin_meta <= 2'h3;
			pin_s    <= 2'h3;
			pin_prev <= 2'h3;
		end
		else
		begin
			pin_meta <= {sda_pin_i, scl_pin_i};
			pin_s    <= pin_meta;
			pin_prev <= pin_s;
		end
	end

	always_ff @(posedge link_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			start_tgl <= 1'b0;
			stop_tgl  <= 1'b0;
		end
		else
		begin
			start_tgl <= start_tgl ^ link_start;
			stop_tgl  <= stop_tgl ^ link_stop;
		end
	end

	// configuration register; busy is never taken from the write data
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
			cfg <= CFG_RESET;
		else if (cfg_wr_i)
			cfg <= {cfg_wdata_i[7:6], 1'b0, cfg_wdata_i[4:0]};
	end

	// set wins over clear, so a START in the stop cycle keeps busy
	always_comb
	begin
		next_busy = cfg.iface_on && (start_evt || (busy && !(stop_evt || bus_free)));
	end

	// inhibit only changes between transfers or at a START
	always_comb
	begin
		next_inh_eff = inh_eff;
		if (start_evt || !busy)
			next_inh_eff = cfg_wr_i ? wr_inhibit : cfg.slave_inhibit;
	end

	always_comb
	begin
		next_free_cnt = free_cnt;
		if (!free_armed)
			next_free_cnt = 4'h0;
		else if (sel_ovf && free_cnt <= FREE_PERIODS)
			next_free_cnt = free_cnt + 4'h1;
	end

	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			busy     <= 1'b0;
			inh_eff  <= 1'b0;
			tgl_prev <= 2'h0;
			free_cnt <= 4'h0;
			bus_free <= 1'b0;
		end
		else
		begin
			busy     <= next_busy;
			inh_eff  <= next_inh_eff;
			tgl_prev <= xq[1:0];
			free_cnt <= next_free_cnt;
			bus_free <= free_hit;
		end
	end

	// master clock: one overflow low, two overflows high; a stretched clock pauses the count
	always_comb
	begin
		next_mst       = mst;
		next_phase_cnt = phase_cnt;
		case (mst)
			M_IDLE:
			begin
				next_phase_cnt = 2'h0;
				if (cfg.iface_on && master_active_i && master_clk_req_i)
					next_mst = M_LOW;
			end
			M_LOW:
			begin
				if (!cfg.iface_on)
					next_mst = M_IDLE;
				else if (sel_ovf && phase_cnt + 2'h1 >= LOW_OVF)
				begin
					next_mst       = M_HIGH;
					next_phase_cnt = 2'h0;
				end
				else if (sel_ovf)
					next_phase_cnt = phase_cnt + 2'h1;
			end
			M_HIGH:
			begin
				if (!cfg.iface_on)
					next_mst = M_IDLE;
				else if (sel_ovf && scl_s && phase_cnt + 2'h1 >= HIGH_OVF)
				begin
					next_phase_cnt = 2'h0;
					next_mst       = master_clk_req_i ? M_LOW : M_IDLE;
				end
				else if (sel_ovf && scl_s)
					next_phase_cnt = phase_cnt + 2'h1;
			end
			default:
			begin
				next_mst       = M_IDLE;
				next_phase_cnt = 2'h0;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			mst       <= M_IDLE;
			phase_cnt <= 2'h0;
		end
		else
		begin
			mst       <= next_mst;
			phase_cnt <= next_phase_cnt;
		end
	end

	always_comb
	begin
		live_cfg                 = cfg;
		live_cfg.transfer_active = busy;
	end

	// registered outputs
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			cfg_rdata_o       <= CFG_RESET;
			scl_o             <= 1'b0;
			scl_oe_o          <= 1'b0;
			reload_hi_o       <= 1'b0;
			reload_lo_o       <= 1'b0;
			irq_event_o       <= 1'b0;
			slave_ack_allow_o <= 1'b0;
			iface_on_o        <= 1'b0;
			setup_cycles_o    <= SETUP_NORM;
			hold_cycles_o     <= HOLD_NORM;
		end
		else
		begin
			cfg_rdata_o       <= live_cfg;
			scl_o             <= 1'b0;
			scl_oe_o          <= (next_mst == M_LOW);
			reload_hi_o       <= hold_reload;
			reload_lo_o       <= hold_reload && !split_mode_i;
			irq_event_o       <= next_irq;
			slave_ack_allow_o <= cfg.iface_on && !next_inh_eff;
			iface_on_o        <= cfg.iface_on;
			setup_cycles_o    <= cfg.hold_extension ? SETUP_EXT : SETUP_NORM;
			hold_cycles_o     <= cfg.hold_extension ? HOLD_EXT : HOLD_NORM;
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	AST_RELOAD_HI: assert property (hold_reload |=> reload_hi_o)
		else $error("timer not held in reload while clock high");
	AST_COUNT_LOW: assert property (!scl_s |=> !reload_hi_o && !reload_lo_o)
		else $error("timer held in reload while clock low");
	AST_SPLIT_LO: assert property (split_mode_i |=> !reload_lo_o)
		else $error("lower byte reloaded in split mode");
	AST_BUSY_SET: assert property (start_evt |=> busy ##1 cfg_rdata_o.transfer_active)
		else $error("busy not set by start");
	AST_BUSY_STOP: assert property (stop_evt && !start_evt |=> !busy)
		else $error("busy not cleared by stop");
	AST_FREE_CLR: assert property (free_hit && !start_evt |=> bus_free ##1 !busy)
		else $error("busy not cleared by free timeout");
	AST_FREE_COUNT: assert property (free_hit |-> $past(free_cnt) == FREE_PERIODS - 4'h1
		|| $past(free_cnt) == FREE_PERIODS)
		else $error("free timeout reached with wrong period count");
	AST_INHIBIT: assert property (slave_event_i && inh_eff && !master_event_i
		|=> !irq_event_o)
		else $error("slave interrupt while inhibited");
	AST_MASTER_IRQ: assert property (master_event_i && cfg.iface_on |=> irq_event_o)
		else $error("master interrupt lost");
	AST_INH_HOLD: assert property (busy && !start_evt |=> $stable(inh_eff))
		else $error("inhibit changed inside a transfer");
	AST_HOLD_EXT: assert property (cfg.hold_extension |=> hold_cycles_o == HOLD_EXT
		&& setup_cycles_o == SETUP_EXT)
		else $error("extended hold timing not selected");
	AST_DISABLED: assert property (!cfg.iface_on |=> !irq_event_o && !busy
		&& !slave_ack_allow_o)
		else $error("activity while interface disabled");
	// disabling the interface ends a low phase early on purpose
	AST_MIN_LOW: assert property (cfg.iface_on && mst == M_LOW && !sel_ovf |=> scl_oe_o)
		else $error("clock low phase shorter than one overflow");
	AST_NO_OVF: assert property (!ovf_used && cfg.iface_on && mst != M_IDLE
		|=> $stable(mst) && $stable(phase_cnt))
		else $error("source used while not needed");
	AST_WR_BUSY: assert property (cfg_wr_i && cfg.iface_on && !start_evt && !stop_evt
		&& !bus_free |=> $stable(busy))
		else $error("write disturbed busy");

	COV_BUSY: cover property (start_evt ##[1:1000] stop_evt);
	COV_FREE: cover property (free_hit);
	COV_MASTER: cover property (mst == M_LOW ##[1:1000] mst == M_HIGH);
	COV_INH: cover property (slave_event_i && inh_eff);
	COV_STRETCH: cover property (mst == M_HIGH && !scl_s);

endmodule : scc_config_control

/* testbench/scc_bus_model.sv */
// partner model: another bus master on the open-drain lines
`timescale 1ns/10ps
module scc_bus_model (
	// dut side
	input  wire logic scl_oe_i,
	// wire levels
	output logic      scl_o,
	output logic      sda_o
);
	logic scl_low;
	logic sda_low;
	initial
	begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end
	// pull-ups: a released line reads high, never the last driven value
	assign scl_o = ~(scl_oe_i | scl_low);
	assign sda_o = ~sda_low;
	// each level stands 60 ns, above the three link periods the sampler needs
	task automatic set_lines(input logic scl, input logic sda);
		scl_low = ~scl;
		sda_low = ~sda;
		#60;
	endtask : set_lines
endmodule : scc_bus_model

/* testbench/testbench.sv */
// self-checking bench for the serial bus configuration block
`timescale 1ns/10ps
module testbench;
	import scc_pkg::*;
	logic              sys_clk_i;
	logic              link_clk_i;
	logic              reset_i;
	logic              cfg_wr_i;
	scc_cfg_t          cfg_wdata_i;
	scc_cfg_t          cfg_rdata_o;
	logic              scl_w;
	logic              sda_w;
	logic              scl_o;
	logic              scl_oe_o;
	logic [3:0]        ovf_i;
	logic              split_mode_i;
	logic              reload_hi_o;
	logic              reload_lo_o;
	logic              m_act;
	logic              m_req;
	logic              m_evt;
	logic              s_evt;
	logic              irq_event_o;
	logic              ack_ok;
	logic              iface_on_o;
	logic [3:0]        setup_cycles_o;
	logic [3:0]        hold_cycles_o;
	int                failures;
	int                tests_run;

	scc_config_control dut (
		.sys_clk_i(sys_clk_i), .reset_i(reset_i), .link_clk_i(link_clk_i),
		.cfg_wr_i(cfg_wr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
		.scl_pin_i(scl_w), .sda_pin_i(sda_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
		.ovf_i(ovf_i), .split_mode_i(split_mode_i), .reload_hi_o(reload_hi_o),
		.reload_lo_o(reload_lo_o), .master_active_i(m_act), .master_clk_req_i(m_req),
		.master_event_i(m_evt), .slave_event_i(s_evt), .irq_event_o(irq_event_o),
		.slave_ack_allow_o(ack_ok), .iface_on_o(iface_on_o),
		.setup_cycles_o(setup_cycles_o), .hold_cycles_o(hold_cycles_o)
	);
	scc_bus_model bus (.scl_oe_i(scl_oe_o), .scl_o(scl_w), .sda_o(sda_w));

	initial
	begin
		sys_clk_i = 1'b0;
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end
	// link clock free running, phase unrelated to the system clock
	initial
	begin
		link_clk_i = 1'b0;
		#1.3;
		forever #7.5 link_clk_i = ~link_clk_i;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask : tick
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] v);
		cfg_wr_i = 1'b1;
		cfg_wdata_i = v;
		tick(1);
		cfg_wr_i = 1'b0;
		tick(2);
	endtask : wr
	// bounded wait on the live busy bit
	task automatic wait_busy(input logic v);
		for (int i = 0; i < 60 && cfg_rdata_o.transfer_active !== v; i++)
			tick(1);
		check({7'h00, cfg_rdata_o.transfer_active}, {7'h00, v});
	endtask : wait_busy
	task automatic pulse(input logic [3:0] o);
		ovf_i = o;
		tick(1);
		ovf_i = 4'h0;
		tick(2);
	endtask : pulse
	task automatic event_irq(input logic m, input logic s, input logic exp);
		m_evt = m;
		s_evt = s;
		tick(1);
		check({7'h00, irq_event_o}, {7'h00, exp});
		m_evt = 1'b0;
		s_evt = 1'b0;
		tick(1);
	endtask : event_irq

	task automatic t_regs();
		check(cfg_rdata_o, 8'h00);
		check({setup_cycles_o, hold_cycles_o}, {SETUP_NORM, HOLD_NORM});
		wr(8'hff);
		check(cfg_rdata_o, 8'hdf);
		check({7'h00, iface_on_o}, 8'h01);
		check({setup_cycles_o, hold_cycles_o}, {SETUP_EXT, HOLD_EXT});
		wr(8'h00);
		check({7'h00, iface_on_o}, 8'h00);
		$display("done: regs");
	endtask : t_regs

	task automatic t_inhibit();
		wr(8'h00);
		bus.set_lines(1'b1, 1'b0);
		bus.set_lines(1'b1, 1'b1);
		tick(20);
		check(cfg_rdata_o, 8'h00);
		wr(8'hc0);
		check({7'h00, ack_ok}, 8'h00);
		event_irq(1'b0, 1'b1, 1'b0);
		event_irq(1'b1, 1'b0, 1'b1);
		wr(8'h80);
		check({7'h00, ack_ok}, 8'h01);
		event_irq(1'b0, 1'b1, 1'b1);
		bus.set_lines(1'b1, 1'b0);
		wait_busy(1'b1);
		wr(8'hc0);
		event_irq(1'b0, 1'b1, 1'b1);
		bus.set_lines(1'b1, 1'b1);
		wait_busy(1'b0);
		bus.set_lines(1'b1, 1'b0);
		wait_busy(1'b1);
		event_irq(1'b0, 1'b1, 1'b0);
		bus.set_lines(1'b1, 1'b1);
		wait_busy(1'b0);
		$display("done: inhibit and busy");
	endtask : t_inhibit

	task automatic t_reload();
		wr(8'h88);
		tick(15);
		check({6'h00, reload_hi_o, reload_lo_o}, 8'h03);
		split_mode_i = 1'b1;
		tick(3);
		check({6'h00, reload_hi_o, reload_lo_o}, 8'h02);
		bus.set_lines(1'b1, 1'b0);
		wait_busy(1'b1);
		bus.set_lines(1'b0, 1'b0);
		bus.set_lines(1'b0, 1'b1);
		tick(15);
		check({6'h00, reload_hi_o, reload_lo_o}, 8'h00);
		// timeout handler restarts the bus by a disable and enable
		wr(8'h08);
		wr(8'h88);
		check({7'h00, cfg_rdata_o.transfer_active}, 8'h00);
		bus.set_lines(1'b1, 1'b1);
		split_mode_i = 1'b0;
		$display("done: timeout reload");
	endtask : t_reload

	// every source code; pulses of the other sources must not count
	task automatic t_free();
		for (int s = 0; s < NUM_SOURCES; s++)
		begin
			wr(8'h84 | 8'(s));
			bus.set_lines(1'b1, 1'b0);
			wait_busy(1'b1);
			bus.set_lines(1'b0, 1'b0);
			bus.set_lines(1'b0, 1'b1);
			bus.set_lines(1'b1, 1'b1);
			tick(15);
			for (int i = 0; i < 10; i++)
			begin
				pulse(4'hf & ~(4'h1 << s));
				pulse(4'h1 << s);
			end
			check({7'h00, cfg_rdata_o.transfer_active}, 8'h01);
			pulse(4'h1 << s);
			wait_busy(1'b0);
		end
		$display("done: free timeout");
	endtask : t_free

	task automatic t_master();
		wr(8'h80);
		m_act = 1'b1;
		m_req = 1'b1;
		tick(2);
		check({6'h00, scl_oe_o, scl_o}, 8'h02);
		pulse(4'h1);
		check({6'h00, scl_oe_o, scl_o}, 8'h00);
		tick(15);
		pulse(4'h1);
		check({7'h00, scl_oe_o}, 8'h00);
		pulse(4'h1);
		check({7'h00, scl_oe_o}, 8'h01);
		m_req = 1'b0;
		m_act = 1'b0;
		pulse(4'h1);
		check({7'h00, scl_oe_o}, 8'h01);
		wr(8'h00);
		$display("done: master clock");
	endtask : t_master

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report

	initial
	begin
		failures = 0;
		tests_run = 0;
		reset_i = 1'b1;
		cfg_wr_i = 1'b0;
		cfg_wdata_i = 8'h00;
		ovf_i = 4'h0;
		split_mode_i = 1'b0;
		{m_act, m_req, m_evt, s_evt} = 4'h0;
		tick(12);
		reset_i = 1'b0;
		tick(1);
		t_regs();
		t_inhibit();
		t_reload();
		t_free();
		t_master();
		final_report();
	end

	// watchdog well beyond the expected run of about a thousand cycles
	initial
	begin
		#200000;
		failures++;
		final_report();
	end
endmodule : testbench
